// >>> verilog/dac_core_pkg.sv
// Purpose: Shared constants, types and CRC helper for the converter control core.
// Assumes: 125 MHz core clock; 24-bit frames, or 32-bit frames with a trailing check byte.
// Notes:   Register indices are the 8-bit address field of a frame.
// Summary of operation
// - Per-channel short-circuit limit select, 16/8 mA
// - Voltage short pulls fault low, sets bit
// - Code = D*(M+1)/4096 + C - 2048
// - One shared multiplier/adder, channels calibrated serially
// - Gain/offset writes wait for next data write
// - Gain and offset words are 12 bits
// - Reset gain 0xfff, offset 0x800, unity
// - Echo bit set: status shifted out each frame
// - Status echo off after reset
// - Echo on: no other register readback
// - Clear rising edge loads per-channel clear code
// - Only clear-allowed channels respond to clear
// - Cleared channels hold until next data write
// - 32-bit frame: check CRC, write only if good
// - CRC mismatch: fault low, frame error bit
// - Status readback clears frame error bit
// - Watchdog: missing key 0x195 raises alarm
// - Watchdog enable and timeout in main control
// - Alarm output active high, push-pull
// - Fault open-drain, active on any fault
package dac_core_pkg;
	localparam logic [7:0]  ADDR_NOP     = 8'h00;
	localparam logic [7:0]  ADDR_DATA    = 8'h01;
	localparam logic [7:0]  ADDR_GAIN    = 8'h05;
	localparam logic [7:0]  ADDR_OFFS    = 8'h09;
	localparam logic [7:0]  ADDR_CLRC    = 8'h0d;
	localparam logic [7:0]  ADDR_CHCTL   = 8'h11;
	localparam logic [7:0]  ADDR_MAIN    = 8'h15;
	localparam logic [7:0]  ADDR_SWKEY   = 8'h16;
	localparam logic [7:0]  ADDR_RDSEL   = 8'h17;
	localparam logic [7:0]  ADDR_STATUS  = 8'h18;
	localparam logic [11:0] GAIN_RST     = 12'hfff;
	localparam logic [11:0] OFFS_RST     = 12'h800;
	localparam logic [11:0] CLRC_RST     = 12'h000;
	localparam logic [1:0]  CHCTL_RST    = 2'h0;
	localparam logic [4:0]  MAIN_RST     = 5'h00;
	localparam int          CHCTL_CLR_ALLOW = 0;
	localparam int          CHCTL_SC_LIMIT  = 1;
	localparam int          MAIN_ECHO    = 0;
	localparam int          MAIN_WD_EN   = 1;
	localparam int          MAIN_WD_SEL  = 2;
	localparam int          MAIN_RDBACK  = 4;
	localparam logic [15:0] WD_KEY       = 16'h0195;
	localparam int          CAL_SHIFT    = 12;
	localparam logic [14:0] CAL_MID      = 15'h0800;
	localparam logic [14:0] CAL_MAX      = 15'h0fff;
	localparam logic [7:0]  CRC_POLY     = 8'h07;
	localparam logic [5:0]  FRAME_SHORT  = 6'h18;
	localparam logic [5:0]  FRAME_LONG   = 6'h20;
	localparam int          CLK_MHZ      = 125;
	localparam int          WD_T0_MS     = 5;
	localparam int          WD_T1_MS     = 10;
	localparam int          WD_T2_MS     = 100;
	localparam int          WD_T3_MS     = 200;
	localparam int          WD_T0_CYC    = WD_T0_MS * CLK_MHZ * 1000;
	localparam int          WD_T1_CYC    = WD_T1_MS * CLK_MHZ * 1000;
	localparam int          WD_T2_CYC    = WD_T2_MS * CLK_MHZ * 1000;
	localparam int          WD_T3_CYC    = WD_T3_MS * CLK_MHZ * 1000;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] data;
	} frame_t;

	typedef struct packed {
		logic [5:0] rsvd;
		logic       frame_err;
		logic       over_temp;
		logic [3:0] vout_fault;
		logic [3:0] iout_fault;
	} status_t;

	typedef enum logic [1:0] {
		CAL_IDLE  = 2'b00,
		CAL_MULT  = 2'b01,
		CAL_STORE = 2'b11
	} cal_state_t;

	function automatic logic [7:0] crc8(input logic [23:0] word);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			c = (c[7] ^ word[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8
endpackage : dac_core_pkg

// >>> verilog/dac_digital_control_core.sv
// Purpose: Digital control core: serial frames, calibration, clear, status, watchdog.
// Assumes: Link clock stops outside frames; frame strobe is active low.
// Notes:   The link side only shifts; all decoding runs on clock_i.
module dac_digital_control_core
	import dac_core_pkg::*;
#(
	parameter int unsigned WD_CYC_0 = WD_T0_CYC,
	parameter int unsigned WD_CYC_1 = WD_T1_CYC,
	parameter int unsigned WD_CYC_2 = WD_T2_CYC,
	parameter int unsigned WD_CYC_3 = WD_T3_CYC
)(
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic              sclk_i,
	input  wire logic              sync_n_i,
	input  wire logic              sdin_i,
	input  wire logic              clear_i,
	input  wire logic [3:0]        vout_short_i,
	input  wire logic [3:0]        iout_comp_i,
	input  wire logic              over_temp_i,
	output logic                   serial_out_o,
	output logic                   fault_out_o,
	output logic                   fault_oe_o,
	output logic                   alert_o,
	output logic [3:0]             sc_limit_o,
	output logic [3:0][11:0]       dac_code_o
);
	// ---------------- Link clock domain ----------------
	logic [31:0]      rx_shift;
	logic [5:0]       rx_count;
	logic             rx_armed;
	logic [15:0]      tx_word;

	// Armed is preset while the strobe is idle, so the first edge of a frame restarts the count
	// and the count survives after the frame for the core side to read.
	always_ff @(posedge sclk_i or posedge rst_i or posedge sync_n_i) begin
		if (rst_i || sync_n_i) begin
			rx_armed <= 1'b1;
		end else begin
			rx_armed <= 1'b0;
		end
	end

	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_shift <= 32'h0000_0000;
			rx_count <= 6'h00;
		end else if (!sync_n_i) begin
			rx_shift <= {rx_shift[30:0], sdin_i};
			if (rx_armed) begin
				rx_count <= 6'h01;
			end else if (rx_count != 6'h3f) begin
				rx_count <= rx_count + 6'h01;
			end
		end
	end

	// Output changes on the falling edge; tx_word is quasi-static, only rewritten between frames
	always_ff @(negedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			serial_out_o <= 1'b0;
		end else if (rx_count != 6'h00 && rx_count <= 6'h10) begin
			serial_out_o <= tx_word[4'(16 - rx_count)];
		end else begin
			serial_out_o <= 1'b0;
		end
	end

	// ---------------- Core clock domain ----------------
	logic [2:0]       sync_pipe;
	logic [2:0]       clear_pipe;
	logic [3:0]       vs_meta, vs_sync, ic_meta, ic_sync;
	logic             ot_meta, ot_sync;
	logic             frame_go, frame_ok, clr_go;
	frame_t           frame;
	logic [23:0]      rx_body;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sync_pipe  <= 3'h7;
			clear_pipe <= 3'h0;
			vs_meta    <= 4'h0;
			vs_sync    <= 4'h0;
			ic_meta    <= 4'h0;
			ic_sync    <= 4'h0;
			ot_meta    <= 1'b0;
			ot_sync    <= 1'b0;
		end else if (ce_i) begin
			sync_pipe  <= {sync_pipe[1:0], sync_n_i};
			clear_pipe <= {clear_pipe[1:0], clear_i};
			vs_meta    <= vout_short_i;
			vs_sync    <= vs_meta;
			ic_meta    <= iout_comp_i;
			ic_sync    <= ic_meta;
			ot_meta    <= over_temp_i;
			ot_sync    <= ot_meta;
		end
	end

	// Frame ends on the synchronised strobe edge; link registers are stable by then
	always_comb begin
		rx_body  = (rx_count == FRAME_LONG) ? rx_shift[31:8] : rx_shift[23:0];
		frame    = frame_t'(rx_body);
		frame_go = ce_i && sync_pipe[1] && !sync_pipe[2]
			&& (rx_count == FRAME_SHORT || rx_count == FRAME_LONG);
		frame_ok = (rx_count == FRAME_SHORT) || (crc8(rx_body) == rx_shift[7:0]);
		clr_go   = ce_i && clear_pipe[1] && !clear_pipe[2];
	end

	logic             wr_go;
	assign wr_go = frame_go && frame_ok;

	// ---------------- Control registers ----------------
	logic [4:0]       main_ctl;
	logic [7:0]       rd_sel;
	logic [3:0][11:0] data_reg, gain_reg, offs_reg, clrc_reg;
	logic [3:0][1:0]  chctl;
	logic [3:0]       data_wr;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			main_ctl <= MAIN_RST;
			rd_sel   <= ADDR_STATUS;
		end else if (wr_go) begin
			if (frame.addr == ADDR_MAIN) begin
				main_ctl <= frame.data[4:0];
			end
			if (frame.addr == ADDR_RDSEL) begin
				rd_sel <= frame.data[7:0];
			end
		end
	end

	genvar g;
	for (g = 0; g < 4; g++) begin : gen_ch
		always_ff @(posedge clock_i or posedge rst_i) begin
			if (rst_i) begin
				data_reg[g] <= 12'h000;
				gain_reg[g] <= GAIN_RST;
				offs_reg[g] <= OFFS_RST;
				clrc_reg[g] <= CLRC_RST;
				chctl[g]    <= CHCTL_RST;
			end else if (wr_go) begin
				if (frame.addr == ADDR_DATA + 8'(g)) begin
					data_reg[g] <= frame.data[11:0];
				end
				if (frame.addr == ADDR_GAIN + 8'(g)) begin
					gain_reg[g] <= frame.data[11:0];
				end
				if (frame.addr == ADDR_OFFS + 8'(g)) begin
					offs_reg[g] <= frame.data[11:0];
				end
				if (frame.addr == ADDR_CLRC + 8'(g)) begin
					clrc_reg[g] <= frame.data[11:0];
				end
				if (frame.addr == ADDR_CHCTL + 8'(g)) begin
					chctl[g] <= frame.data[1:0];
				end
			end
		end
		// Only data writes queue a calibration; gain/offset alone leave the output alone
		assign data_wr[g] = wr_go && frame.addr == ADDR_DATA + 8'(g);

		always_ff @(posedge clock_i or posedge rst_i) begin
			if (rst_i) begin
				sc_limit_o[g] <= 1'b0;
			end else if (ce_i) begin
				sc_limit_o[g] <= chctl[g][CHCTL_SC_LIMIT];
			end
		end
	end

	// ---------------- Shared calibration engine ----------------
	cal_state_t       cal_state;
	logic [3:0]       pending;
	logic [1:0]       cal_ch;
	logic [12:0]      cal_prod;
	logic [14:0]      cal_sum;
	logic [11:0]      cal_result;
	logic [1:0]       next_ch;
	logic [3:0]       clr_hit;

	always_comb begin
		next_ch = 2'd0;
		for (int i = 0; i < 4; i++) begin
			clr_hit[i] = clr_go && chctl[i][CHCTL_CLR_ALLOW];
		end
		// A channel being cleared this cycle is not picked for calibration
		for (int i = 3; i >= 0; i--) begin
			if (pending[i] && !clr_hit[i]) begin
				next_ch = 2'(i);
			end
		end
		// Signed headroom: the sum may go below zero or past full scale and is clamped
		cal_sum = {2'b00, cal_prod} + {3'b000, offs_reg[cal_ch]} - CAL_MID;
		if (cal_sum[14]) begin
			cal_result = 12'h000;
		end else if (cal_sum > CAL_MAX) begin
			cal_result = 12'hfff;
		end else begin
			cal_result = cal_sum[11:0];
		end
	end

	// One channel at a time through the single multiplier and adder
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cal_state <= CAL_IDLE;
			cal_ch    <= 2'd0;
			cal_prod  <= 13'h0000;
		end else if (ce_i) begin
			case (cal_state)
				CAL_IDLE: begin
					if (|(pending & ~clr_hit)) begin
						cal_ch    <= next_ch;
						cal_state <= CAL_MULT;
					end
				end
				CAL_MULT: begin
					cal_prod  <= 13'((25'(data_reg[cal_ch]) * (25'(gain_reg[cal_ch]) + 25'd1))
						>> CAL_SHIFT);
					// A clear during the multiply drops the result so it cannot overwrite the clear code
					cal_state <= clr_hit[cal_ch] ? CAL_IDLE : CAL_STORE;
				end
				CAL_STORE: begin
					cal_state <= CAL_IDLE;
				end
				default: begin
					cal_state <= CAL_IDLE;
				end
			endcase
		end
	end

	logic [3:0]       cal_done;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cal_done[i] = ce_i && cal_state == CAL_STORE && cal_ch == 2'(i);
		end
	end

	// A new data write wins over the completion of an older one on the same channel
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pending <= 4'h0;
		end else begin
			pending <= ((pending & ~(cal_state == CAL_MULT && ce_i ? 4'(1 << cal_ch) : 4'h0))
				| data_wr) & ~clr_hit;
		end
	end

	for (g = 0; g < 4; g++) begin : gen_out
		always_ff @(posedge clock_i or posedge rst_i) begin
			if (rst_i) begin
				dac_code_o[g] <= 12'h000;
			end else if (clr_hit[g]) begin
				dac_code_o[g] <= clrc_reg[g];
			end else if (cal_done[g]) begin
				dac_code_o[g] <= cal_result;
			end
		end
	end

	// ---------------- Status and fault ----------------
	status_t          status;
	logic             rd_status;

	assign rd_status = frame_go && (main_ctl[MAIN_ECHO] || rd_sel == ADDR_STATUS);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			status <= '0;
		end else if (ce_i) begin
			status.iout_fault <= ic_sync;
			status.vout_fault <= vs_sync;
			status.over_temp  <= ot_sync;
			if (frame_go && !frame_ok) begin
				status.frame_err <= 1'b1;
			end else if (rd_status) begin
				status.frame_err <= 1'b0;
			end
		end
	end

	// Open-drain: the pin only ever sinks, the pull-up supplies the high level
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fault_out_o <= 1'b0;
			fault_oe_o  <= 1'b0;
		end else if (ce_i) begin
			fault_out_o <= 1'b0;
			fault_oe_o  <= |{status.frame_err, status.over_temp,
				status.vout_fault, status.iout_fault};
		end
	end

	// Word for the next frame; echo snapshots status as it stood at the end of the last frame
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tx_word <= 16'h0000;
		end else if (frame_go) begin
			if (main_ctl[MAIN_ECHO]) begin
				tx_word <= status;
			end else begin
				case (rd_sel)
					ADDR_STATUS: tx_word <= status;
					ADDR_MAIN:   tx_word <= {11'h000, main_ctl};
					default: begin
						if (rd_sel >= ADDR_DATA && rd_sel < ADDR_CHCTL + 8'd4) begin
							tx_word <= {4'h0, rd_sel < ADDR_GAIN ? data_reg[2'(rd_sel - ADDR_DATA)]
								: rd_sel < ADDR_OFFS ? gain_reg[2'(rd_sel - ADDR_GAIN)]
								: rd_sel < ADDR_CLRC ? offs_reg[2'(rd_sel - ADDR_OFFS)]
								: rd_sel < ADDR_CHCTL ? clrc_reg[2'(rd_sel - ADDR_CLRC)]
								: {10'h000, chctl[2'(rd_sel - ADDR_CHCTL)]}};
						end else begin
							tx_word <= 16'h0000;
						end
					end
				endcase
			end
		end
	end

	// ---------------- Watchdog ----------------
	logic [27:0]      wd_count;
	logic [27:0]      wd_limit;
	logic             wd_kick;

	assign wd_kick = wr_go && frame.addr == ADDR_SWKEY && frame.data == WD_KEY;

	always_comb begin
		case (main_ctl[MAIN_WD_SEL +: 2])
			2'd0:    wd_limit = 28'(WD_CYC_0);
			2'd1:    wd_limit = 28'(WD_CYC_1);
			2'd2:    wd_limit = 28'(WD_CYC_2);
			default: wd_limit = 28'(WD_CYC_3);
		endcase
	end

	// The alarm stays raised until the key arrives or the watchdog is disabled; wiring it to clear_i gives one clear edge
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wd_count <= 28'h0000000;
			alert_o  <= 1'b0;
		end else if (ce_i) begin
			if (!main_ctl[MAIN_WD_EN] || wd_kick) begin
				wd_count <= 28'h0000000;
				alert_o  <= 1'b0;
			end else if (wd_count >= wd_limit - 28'd1) begin
				alert_o  <= 1'b1;
			end else begin
				wd_count <= wd_count + 28'd1;
			end
		end
	end

	// ---------------- Checks ----------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	chk_crc_bad_flag: assert property (frame_go && !frame_ok
		|=> status.frame_err ##1 fault_oe_o)
		else $error("bad check byte did not raise frame error and fault");
	chk_crc_bad_quiet: assert property (frame_go && !frame_ok |=> $stable(main_ctl)
		&& $stable(gain_reg) && $stable(data_reg) && $stable(pending))
		else $error("failed frame changed a register");
	chk_status_clr: assert property (rd_status && frame_ok |=> !status.frame_err)
		else $error("status read did not clear frame error");
	chk_echo_word: assert property (frame_go && main_ctl[MAIN_ECHO]
		|=> tx_word == $past(status))
		else $error("echo word is not the status snapshot");
	chk_cal_store: assert property (cal_done[0] && !clr_hit[0]
		|=> dac_code_o[0] == $past(cal_result))
		else $error("calibrated code not stored");
	chk_cal_serial: assert property (cal_state == CAL_MULT && ce_i && !clr_hit[cal_ch]
		|=> cal_state == CAL_STORE ##1 cal_state != CAL_STORE)
		else $error("shared calibration did not step in order");
	chk_gain_hold: assert property (wr_go && frame.addr >= ADDR_GAIN && frame.addr < ADDR_CLRC
		&& pending == 4'h0 && cal_state == CAL_IDLE && !clr_go |=> $stable(dac_code_o) [*2])
		else $error("gain write moved an output");
	chk_clear_load: assert property (clr_hit[0] |=> dac_code_o[0] == $past(clrc_reg[0]))
		else $error("clear code not loaded");
	chk_clear_skip: assert property (clr_go && !chctl[1][CHCTL_CLR_ALLOW] && !cal_done[1]
		|=> $stable(dac_code_o[1]))
		else $error("clear moved a disallowed channel");
	chk_wd_alarm: assert property (ce_i && main_ctl[MAIN_WD_EN] && !wd_kick
		&& wd_count == wd_limit - 28'd1 |=> alert_o)
		else $error("watchdog expiry did not raise alarm");

	cov_crc_fail: cover property (frame_go && !frame_ok);
	cov_clear_two: cover property (clr_go && clr_hit[0] && clr_hit[1]);
	cov_cal_back: cover property (cal_done[2] ##[1:200] cal_done[3]);
	cov_wd_alarm: cover property ($rose(alert_o));
endmodule : dac_digital_control_core

// >>> verification/host_link_model.sv
// Purpose: Behavioural host that drives the three-wire link of the control core.
// Assumes: Link clock idles high, 32 ns period, running only inside frames.
// Notes:   Readback word is collected on rises 2 to 17; frame start phase drifts.
module host_link_model (
	output logic      sclk_o,
	output logic      sync_n_o,
	output logic      sdin_o,
	input  wire logic serial_out_i
);
	timeunit 1ns;
	timeprecision 100ps;

	int fr;

	initial begin
		sclk_o   = 1'b1;
		sync_n_o = 1'b1;
		sdin_o   = 1'b0;
		fr       = 0;
	end

	function automatic logic [7:0] host_crc(input logic [23:0] w);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : host_crc

	// Only the 16-bit word is returned, so an echoed check byte is never used
	task automatic xfer(input logic [7:0] a, input logic [15:0] d, input logic crc_on,
		input logic crc_bad, output logic [15:0] rd);
		logic [31:0] w;
		int          n;
		w  = crc_on ? {a, d, host_crc({a, d}) ^ {7'h00, crc_bad}} : {8'h00, a, d};
		n  = crc_on ? 32 : 24;
		rd = 16'h0000;
		fr++;
		// Varying offset keeps the link clock unrelated in phase to the core clock
		#(0.7 * (fr % 11));
		sync_n_o = 1'b0;
		#16;
		for (int k = 0; k < n; k++) begin
			sclk_o = 1'b0;
			sdin_o = w[n-1-k];
			#16;
			sclk_o = 1'b1;
			if (k >= 1 && k <= 16) rd = {rd[14:0], serial_out_i};
			#16;
		end
		#16;
		sync_n_o = 1'b1;
		sdin_o   = ~sdin_o;
		#64;
	endtask : xfer
endmodule : host_link_model

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the converter control core.
// Assumes: Short watchdog limits; host model owns the link pins.
// Notes:   Registers are reached only through link frames.
module tb_top import dac_core_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int unsigned WD_C [4] = '{50, 100, 200, 400};

	logic             clock_i, rst_i, ce_i, sclk_i, sync_n_i, sdin_i, clear_i, over_temp_i;
	logic [3:0]       vout_short_i, iout_comp_i, sc_limit_o;
	logic             serial_out_o, fault_out_o, fault_oe_o, alert_o;
	logic [3:0][11:0] dac_code_o;
	logic [15:0]      rd;
	int               errors, tests_run, cycles;
	real              t0;
	int               el;

	dac_digital_control_core #(
		.WD_CYC_0(WD_C[0]), .WD_CYC_1(WD_C[1]), .WD_CYC_2(WD_C[2]), .WD_CYC_3(WD_C[3])
	) dut_u (
		.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk_i),
		.sync_n_i(sync_n_i), .sdin_i(sdin_i), .clear_i(clear_i),
		.vout_short_i(vout_short_i), .iout_comp_i(iout_comp_i), .over_temp_i(over_temp_i),
		.serial_out_o(serial_out_o), .fault_out_o(fault_out_o), .fault_oe_o(fault_oe_o),
		.alert_o(alert_o), .sc_limit_o(sc_limit_o), .dac_code_o(dac_code_o)
	);

	host_link_model host_u (
		.sclk_o(sclk_i), .sync_n_o(sync_n_i), .sdin_o(sdin_i), .serial_out_i(serial_out_o)
	);

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	task automatic end_sim;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrx(input logic [7:0] a, input logic [15:0] d, input logic c, input logic b);
		logic [15:0] r;
		host_u.xfer(a, d, c, b, r);
		repeat (10) @(posedge clock_i);
		#1;
	endtask : wrx

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		wrx(a, d, 1'b0, 1'b0);
	endtask : wr

	// The word is loaded at a frame end, so it appears one frame later
	task automatic rdreg(input logic [7:0] a, output logic [15:0] r);
		wr(ADDR_RDSEL, {8'h00, a});
		wr(ADDR_NOP, 16'h0000);
		host_u.xfer(ADDR_NOP, 16'h0000, 1'b0, 1'b0, r);
	endtask : rdreg

	task automatic waitc;
		repeat (8) @(posedge clock_i);
		#1;
	endtask : waitc

	function automatic logic [11:0] cal(input int d, input int m, input int c);
		int v;
		v = d * (m + 1) / 4096 + c - 2048;
		v = v < 0 ? 0 : (v > 4095 ? 4095 : v);
		return v[11:0];
	endfunction : cal

	initial begin
		{errors, tests_run, cycles} = '0;
		{rst_i, ce_i, clear_i, over_temp_i} = 4'b1100;
		vout_short_i = 4'h0;
		iout_comp_i  = 4'h0;
		repeat (10) @(posedge clock_i);
		#1 rst_i = 1'b0;
		waitc();
		rdreg(ADDR_GAIN, rd); chk(rd, 16'h0fff);
		rdreg(ADDR_OFFS, rd); chk(rd, 16'h0800);
		wr(ADDR_DATA, 16'h0123); chk(16'(dac_code_o[0]), 16'h0123);
		wr(ADDR_GAIN + 8'h01, 16'hf7ff);
		wr(ADDR_OFFS + 8'h01, 16'h0900); chk(16'(dac_code_o[1]), 16'h0000);
		rdreg(ADDR_GAIN + 8'h01, rd); chk(rd, 16'h07ff);
		wr(ADDR_DATA + 8'h01, 16'h0a00);
		chk(16'(dac_code_o[1]), 16'(cal(2560, 2047, 2304)));
		host_u.xfer(ADDR_DATA + 8'h02, 16'h0fff, 1'b0, 1'b0, rd);
		wr(ADDR_DATA + 8'h03, 16'h0001);
		chk(16'(dac_code_o[2]), 16'h0fff);
		chk(16'(dac_code_o[3]), 16'h0001);
		wr(ADDR_CHCTL, 16'h0003);
		wr(ADDR_CHCTL + 8'h02, 16'h0002); chk(16'(sc_limit_o), 16'h0005);
		wr(ADDR_CLRC, 16'h0abc);
		wr(ADDR_CLRC + 8'h01, 16'h0111);
		clear_i = 1'b1;
		waitc();
		chk(16'(dac_code_o[0]), 16'h0abc);
		chk(16'(dac_code_o[1]), 16'(cal(2560, 2047, 2304)));
		clear_i = 1'b0;
		waitc();
		chk(16'(dac_code_o[0]), 16'h0abc);
		wr(ADDR_DATA, 16'h0456); chk(16'(dac_code_o[0]), 16'h0456);
		wr(ADDR_RDSEL, 16'h0018);
		wrx(ADDR_DATA + 8'h03, 16'h0321, 1'b1, 1'b0); chk(16'(dac_code_o[3]), 16'h0321);
		wrx(ADDR_DATA + 8'h03, 16'h0777, 1'b1, 1'b1); chk(16'(dac_code_o[3]), 16'h0321);
		chk(16'(fault_oe_o), 16'h0001);
		chk(16'(fault_oe_o ? fault_out_o : 1'b1), 16'h0000);
		wr(ADDR_NOP, 16'h0000); chk(16'(fault_oe_o), 16'h0000);
		for (int i = 0; i < 3; i++) begin
			vout_short_i = (i == 0) ? 4'h4 : 4'h0;
			iout_comp_i  = (i == 1) ? 4'h2 : 4'h0;
			over_temp_i  = (i == 2);
			waitc();
			chk(16'(fault_oe_o), 16'h0001);
			rdreg(ADDR_STATUS, rd); chk(rd, i == 0 ? 16'h0040 : (i == 1 ? 16'h0002 : 16'h0100));
			@(posedge clock_i);
			#1 {vout_short_i, iout_comp_i, over_temp_i} = '0;
			waitc();
			chk(16'(fault_oe_o), 16'h0000);
		end
		wr(ADDR_MAIN, 16'h0001);
		over_temp_i = 1'b1;
		wr(ADDR_RDSEL, 16'h0005);
		wr(ADDR_NOP, 16'h0000);
		host_u.xfer(ADDR_NOP, 16'h0000, 1'b0, 1'b0, rd); chk(rd, 16'h0100);
		over_temp_i = 1'b0;
		wr(ADDR_MAIN, 16'h0000);
		rdreg(ADDR_GAIN, rd); chk(rd, 16'h0fff);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_MAIN, 16'(s * 4 + 2));
			host_u.xfer(ADDR_SWKEY, WD_KEY, 1'b0, 1'b0, rd);
			t0 = $realtime;
			chk(16'(alert_o), 16'h0000);
			// A rejected key must not restart the count
			if (s == 3) host_u.xfer(ADDR_SWKEY, WD_KEY, 1'b1, 1'b1, rd);
			while (alert_o !== 1'b1 && ($realtime - t0) < 8000.0) @(posedge clock_i);
			el = int'(($realtime - t0) / 8.0);
			chk(16'(el >= int'(WD_C[s]) - 12 && el <= int'(WD_C[s]) + 4), 16'h0001);
		end
		wr(ADDR_MAIN, 16'h0000); chk(16'(alert_o), 16'h0000);
		end_sim();
	end
endmodule : tb_top
